// ---- fiwp_flash_model.sv ----
/*
  Flash engine stand-in: self-timed cycle with optional faults.
  Assumes start and abort pulses come from the guard on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module fiwp_flash_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  // cycle control
  input  wire logic       cyc_start_q,
  input  wire logic       cyc_abort_q,
  input  wire logic [7:0] busy_cycles,
  input  wire logic       fail_verify,
  input  wire logic       fail_hv,
  // cycle result
  output logic            cyc_done,
  output logic            hv_fault,
  output logic            verify_mismatch
);
  logic [7:0] cnt_q;
  logic       busy_q;
  logic       junk_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (cyc_start_q) begin
      busy_q <= 1'b1;
      cnt_q  <= busy_cycles;
    end else if (cyc_abort_q || (busy_q && cnt_q == 8'h00)) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end

  // verify line means nothing outside done, so keep it moving
  always_ff @(posedge clk_sys) begin
    junk_q <= srst ? 1'b0 : ~junk_q;
  end

  assign cyc_done        = busy_q && cnt_q == 8'h00 && !fail_hv;
  assign hv_fault        = busy_q && cnt_q == 8'h00 && fail_hv;
  assign verify_mismatch = cyc_done ? fail_verify : junk_q;
endmodule : fiwp_flash_model
`default_nettype wire

// ---- fiwp_guard.sv ----
/*
  Flash programming guard: entry dispatch, key check, write enable,
  configuration protection, self-timed cycle control and error status.
  Assumes CPU-side strobes and flash engine signals share clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none

module fiwp_guard #(
  // version byte returned by the version call; value is arbitrary
  parameter logic [7:0] VERSION_ID = 8'h01
) (
  // clock and reset
  input  wire logic                    clk_sys,
  input  wire logic                    srst,
  input  wire logic                    clk_en,
  // call from CPU
  input  wire logic                    call_valid,
  input  wire logic [15:0]             call_addr,
  input  wire logic [7:0]              call_func,
  input  wire logic [7:0]              call_target,
  input  wire logic [7:0]              call_data,
  input  wire logic [7:0]              key_byte,
  input  wire fiwp_pkg::fiwp_mode_type prog_mode,
  output logic                         call_ready,
  // call result
  output logic                         call_done_q,
  output logic                         carry_q,
  output logic [7:0]                   status_q,
  output logic [7:0]                   result_q,
  output logic                         key_clear_q,
  output logic                         mcu_reset_q,
  output logic                         cpu_idle,
  // flash command and data registers
  input  wire logic                    fcmd_we,
  input  wire logic [7:0]              fcmd_wdata,
  input  wire logic                    fdata_we,
  input  wire logic [7:0]              fdata_wdata,
  // flash engine
  output logic                         cyc_start_q,
  output logic                         cyc_abort_q,
  input  wire logic                    cyc_done,
  input  wire logic                    hv_fault,
  input  wire logic                    verify_mismatch,
  input  wire logic                    security_block,
  input  wire logic                    irq_pending,
  // protection state
  output logic                         write_enable,
  output logic [7:0]                   boot_status
);

  fiwp_pkg::fiwp_state_type state_q;
  fiwp_pkg::fiwp_state_type state_d;

  logic [7:0] func_q;
  logic [7:0] target_q;
  logic [7:0] data_q;
  logic [7:0] rd_data_q;
  logic [7:0] cfg_q [fiwp_pkg::CFG_COUNT];
  logic       we_flag_q;
  logic       key_set;
  logic       key_clr;

  logic       accept;
  logic       keyed_call;
  logic       is_write;
  logic       uses_engine;
  logic       guarded;
  logic       cfg_target;
  logic       ccp_target;
  logic       write_enable_activate;
  logic       config_write_protect;
  logic       disable_protect_clear;
  logic       violation;
  logic       key_fail;
  logic [3:0] flag_set;
  logic [3:0] flag_q;

  assign boot_status  = cfg_q[fiwp_pkg::CFG_BOOT];
  assign write_enable_activate          = boot_status[fiwp_pkg::BS_AWE_BIT];
  assign config_write_protect          = boot_status[fiwp_pkg::BS_CWP_BIT];
  assign disable_protect_clear         = boot_status[fiwp_pkg::BS_DISABLE_PROTECT_CLEAR_BIT];
  assign write_enable = !write_enable_activate || we_flag_q;
  assign call_ready   = (state_q == fiwp_pkg::ST_IDLE);
  assign cpu_idle     = (state_q == fiwp_pkg::ST_CYCLE);
  assign status_q     = {fiwp_pkg::ST_UNUSED, flag_q};

  // only a call landing on the shared entry is dispatched
  assign accept     = call_ready && call_valid && call_addr == fiwp_pkg::ENTRY_ADDR;
  assign keyed_call = call_func == fiwp_pkg::FN_PROGRAM || call_func == fiwp_pkg::FN_ERASE;
  assign key_fail   = accept && keyed_call && key_byte != fiwp_pkg::KEY_VALUE;

  assign is_write    = func_q == fiwp_pkg::FN_PROGRAM || func_q == fiwp_pkg::FN_ERASE
                       || func_q == fiwp_pkg::FN_MISC_WR;
  assign uses_engine = func_q == fiwp_pkg::FN_PROGRAM || func_q == fiwp_pkg::FN_ERASE
                       || func_q == fiwp_pkg::FN_SECT_CRC || func_q == fiwp_pkg::FN_GLOB_CRC;
  assign guarded     = prog_mode == fiwp_pkg::MODE_IAP || prog_mode == fiwp_pkg::MODE_ISP;
  assign cfg_target  = func_q == fiwp_pkg::FN_MISC_WR && target_q <= fiwp_pkg::TG_CFG_LAST;
  assign ccp_target  = func_q == fiwp_pkg::FN_MISC_WR && target_q == fiwp_pkg::TG_CCP;

  always_comb begin
    violation = 1'b0;
    if (uses_engine && security_block) begin
      violation = 1'b1;
    end
    if (guarded && is_write && !write_enable) begin
      violation = 1'b1;
    end
    if (guarded && cfg_target && config_write_protect) begin
      violation = 1'b1;
    end
    if (guarded && ccp_target && disable_protect_clear) begin
      violation = 1'b1;
    end
  end

  fiwp_key_cmd u_key_cmd (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .clk_en      (clk_en),
    .fcmd_we     (fcmd_we),
    .fcmd_wdata  (fcmd_wdata),
    .fdata_we    (fdata_we),
    .fdata_wdata (fdata_wdata),
    .set_q       (key_set),
    .clr_q       (key_clr)
  );

  // flag sets: abort, security, voltage, verify
  always_comb begin
    flag_set = 4'h0;
    if (state_q == fiwp_pkg::ST_CHECK) begin
      flag_set[fiwp_pkg::ST_SV] = violation;
    end
    if (state_q == fiwp_pkg::ST_CYCLE) begin
      flag_set[fiwp_pkg::ST_OI]  = irq_pending;
      flag_set[fiwp_pkg::ST_HVE] = !irq_pending && hv_fault;
      flag_set[fiwp_pkg::ST_VE]  = !irq_pending && !hv_fault && cyc_done && verify_mismatch
                                   && func_q == fiwp_pkg::FN_PROGRAM;
    end
  end

  for (genvar i = 0; i < fiwp_pkg::ST_FLAGS; i++) begin : g_flag
    fiwp_status_flag u_flag (
      .clk_sys (clk_sys),
      .srst    (srst),
      .clk_en  (clk_en),
      .set     (flag_set[i]),
      .clr     (accept),
      .flag_q  (flag_q[i])
    );
  end

  // call sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fiwp_pkg::ST_IDLE: begin
        if (accept && !key_fail) begin
          state_d = fiwp_pkg::ST_CHECK;
        end
      end
      fiwp_pkg::ST_CHECK: begin
        if (!violation && uses_engine) begin
          state_d = fiwp_pkg::ST_CYCLE;
        end else begin
          state_d = fiwp_pkg::ST_DONE;
        end
      end
      fiwp_pkg::ST_CYCLE: begin
        if (irq_pending || hv_fault || cyc_done) begin
          state_d = fiwp_pkg::ST_DONE;
        end
      end
      fiwp_pkg::ST_DONE: begin
        state_d = fiwp_pkg::ST_IDLE;
      end
      default: begin
        state_d = fiwp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= fiwp_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      func_q   <= fiwp_pkg::DATA_ZERO;
      target_q <= fiwp_pkg::DATA_ZERO;
      data_q   <= fiwp_pkg::DATA_ZERO;
    end else if (clk_en && accept) begin
      func_q   <= call_func;
      target_q <= call_target;
      data_q   <= call_data;
    end
  end

  // flash engine strobes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cyc_start_q <= 1'b0;
      cyc_abort_q <= 1'b0;
    end else if (clk_en) begin
      cyc_start_q <= state_q == fiwp_pkg::ST_CHECK && !violation && uses_engine;
      cyc_abort_q <= state_q == fiwp_pkg::ST_CYCLE && (irq_pending || hv_fault);
    end
  end

  // software write enable; a set beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      we_flag_q <= 1'b0;
    end else if (clk_en) begin
      if (key_set || (accept && prog_mode == fiwp_pkg::MODE_ISP)) begin
        we_flag_q <= 1'b1;
      end else if (key_clr || (state_q == fiwp_pkg::ST_DONE && is_write)) begin
        we_flag_q <= 1'b0;
      end
    end
  end

  // config bytes held in flops; no nonvolatile backing modelled here
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < fiwp_pkg::CFG_COUNT; i++) begin
        cfg_q[i] <= fiwp_pkg::CFG_RESET;
      end
    end else if (clk_en && state_q == fiwp_pkg::ST_CHECK && !violation) begin
      if (cfg_target) begin
        cfg_q[target_q[1:0]] <= data_q;
      end else if (ccp_target) begin
        cfg_q[fiwp_pkg::CFG_BOOT][fiwp_pkg::BS_CWP_BIT] <= 1'b0;
        if (!guarded) begin
          cfg_q[fiwp_pkg::CFG_BOOT][fiwp_pkg::BS_DISABLE_PROTECT_CLEAR_BIT] <= 1'b0;
        end
      end
    end
  end

  // read data captured while checking
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data_q <= fiwp_pkg::DATA_ZERO;
    end else if (clk_en && state_q == fiwp_pkg::ST_CHECK) begin
      if (func_q == fiwp_pkg::FN_VERSION) begin
        rd_data_q <= VERSION_ID;
      end else if (func_q == fiwp_pkg::FN_MISC_RD && target_q <= fiwp_pkg::TG_CFG_LAST) begin
        rd_data_q <= cfg_q[target_q[1:0]];
      end else begin
        rd_data_q <= fiwp_pkg::DATA_ZERO;
      end
    end
  end

  // completion; carry and result stand until the next completion, done and key clear pulse for one cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      call_done_q <= 1'b0;
      key_clear_q <= 1'b0;
      carry_q     <= 1'b0;
      result_q    <= fiwp_pkg::DATA_ZERO;
    end else if (clk_en) begin
      call_done_q <= state_q == fiwp_pkg::ST_DONE;
      key_clear_q <= state_q == fiwp_pkg::ST_DONE;
      if (state_q == fiwp_pkg::ST_DONE) begin
        carry_q  <= |flag_q;
        result_q <= (|flag_q) ? status_q : rd_data_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mcu_reset_q <= 1'b0;
    end else if (clk_en) begin
      mcu_reset_q <= key_fail;
    end
  end

  // checks
  sequence s_set_we;
    clk_en && fcmd_we && fcmd_wdata == fiwp_pkg::CMD_SET_WE
    ##1 clk_en && !fcmd_we && fdata_we && fdata_wdata == fiwp_pkg::KEY_VALUE;
  endsequence

  sequence s_clr_we;
    clk_en && fcmd_we && fcmd_wdata == fiwp_pkg::CMD_CLR_WE
    ##1 clk_en && !fcmd_we && fdata_we && fdata_wdata == fiwp_pkg::KEY_VALUE;
  endsequence

  a_key_reset: assert property (@(posedge clk_sys) disable iff (srst)
    key_fail && clk_en |=> mcu_reset_q && state_q == fiwp_pkg::ST_IDLE)
    else $error("bad key did not reset");

  a_key_clear_done: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_DONE && clk_en |=> key_clear_q && call_done_q)
    else $error("key not cleared at call end");

  a_we_forced: assert property (@(posedge clk_sys) disable iff (srst)
    !boot_status[fiwp_pkg::BS_AWE_BIT] |-> write_enable)
    else $error("write enable not forced");

  a_we_key_set: assert property (@(posedge clk_sys) disable iff (srst)
    s_set_we ##1 clk_en |=> we_flag_q)
    else $error("keyed set missed");

  a_we_key_clr: assert property (@(posedge clk_sys) disable iff (srst)
    s_clr_we ##1 (clk_en && !accept) |=> !we_flag_q)
    else $error("keyed clear missed");

  a_we_block: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_CHECK && clk_en && guarded && is_write && !write_enable
    |=> flag_q[fiwp_pkg::ST_SV] && !cyc_start_q)
    else $error("write passed with flag clear");

  a_cwp_block: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_CHECK && clk_en && guarded && cfg_target && config_write_protect
    |=> flag_q[fiwp_pkg::ST_SV] && $stable(boot_status))
    else $error("protected config written");

  a_disable_protect_clear_refuse: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_CHECK && clk_en && guarded && ccp_target && disable_protect_clear
    |=> $stable(config_write_protect) && flag_q[fiwp_pkg::ST_SV])
    else $error("locked clear honoured");

  a_ccp_unguarded: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_CHECK && clk_en && !guarded && ccp_target
    |=> !disable_protect_clear && !config_write_protect && !flag_q[fiwp_pkg::ST_SV])
    else $error("unguarded clear failed");

  a_irq_abort: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_CYCLE && clk_en && irq_pending
    |=> cyc_abort_q && flag_q[fiwp_pkg::ST_OI] ##1 !clk_en || call_done_q)
    else $error("interrupt did not abort cycle");

  a_hv_error: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_CYCLE && clk_en && !irq_pending && hv_fault
    |=> cyc_abort_q && flag_q[fiwp_pkg::ST_HVE])
    else $error("voltage fault not flagged");

  a_verify_error: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_CYCLE && clk_en && !irq_pending && !hv_fault && cyc_done
    && verify_mismatch && func_q == fiwp_pkg::FN_PROGRAM |=> flag_q[fiwp_pkg::ST_VE])
    else $error("verify mismatch not flagged");

  a_cycle_idle: assert property (@(posedge clk_sys) disable iff (srst)
    cyc_start_q |-> cpu_idle)
    else $error("cpu not idle during cycle");

  a_carry_status: assert property (@(posedge clk_sys) disable iff (srst)
    call_done_q |-> carry_q == (result_q == status_q && status_q != 8'h00)
    && status_q[7:4] == 4'h0)
    else $error("carry and status disagree");

  a_write_clears: assert property (@(posedge clk_sys) disable iff (srst)
    state_q == fiwp_pkg::ST_DONE && clk_en && is_write && !key_set |=> !we_flag_q)
    else $error("flag left set after write");

endmodule : fiwp_guard
`default_nettype wire

// ---- fiwp_guard_tb.sv ----
/*
  Self-checking bench for the flash write guard.
  Acts as the CPU; the flash engine model answers cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module fiwp_guard_tb;
  typedef struct packed {
    logic       carry;
    logic [7:0] res;
    logic [7:0] mask;
  } fiwp_note_type;

  localparam logic [7:0] VER = 8'h5c; // arbitrary value
  logic clk_sys, srst, clk_en, call_valid, fcmd_we, fdata_we, security_block, irq_pending;
  logic call_ready, call_done_q, carry_q, key_clear_q, mcu_reset_q, cpu_idle;
  logic cyc_start_q, cyc_abort_q, cyc_done, hv_fault, verify_mismatch, write_enable;
  logic fail_verify, fail_hv;
  logic [15:0] call_addr;
  logic [7:0]  call_func, call_target, call_data, key_byte, fcmd_wdata, fdata_wdata;
  logic [7:0]  status_q, result_q, boot_status, busy_cycles;
  logic [7:0]  rv [3];
  logic [31:0] lfsr_q;
  fiwp_pkg::fiwp_mode_type prog_mode;
  fiwp_note_type notes[$];
  fiwp_note_type nt;
  int err_count, n_compared;

  fiwp_guard #(.VERSION_ID(VER)) i_fiwp_guard (
    .clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .call_valid(call_valid),
    .call_addr(call_addr), .call_func(call_func), .call_target(call_target),
    .call_data(call_data), .key_byte(key_byte), .prog_mode(prog_mode),
    .call_ready(call_ready), .call_done_q(call_done_q), .carry_q(carry_q),
    .status_q(status_q), .result_q(result_q), .key_clear_q(key_clear_q),
    .mcu_reset_q(mcu_reset_q), .cpu_idle(cpu_idle), .fcmd_we(fcmd_we),
    .fcmd_wdata(fcmd_wdata), .fdata_we(fdata_we), .fdata_wdata(fdata_wdata),
    .cyc_start_q(cyc_start_q), .cyc_abort_q(cyc_abort_q), .cyc_done(cyc_done),
    .hv_fault(hv_fault), .verify_mismatch(verify_mismatch),
    .security_block(security_block), .irq_pending(irq_pending),
    .write_enable(write_enable), .boot_status(boot_status));

  fiwp_flash_model i_fiwp_flash_model (
    .clk_sys(clk_sys), .srst(srst), .cyc_start_q(cyc_start_q),
    .cyc_abort_q(cyc_abort_q), .busy_cycles(busy_cycles), .fail_verify(fail_verify),
    .fail_hv(fail_hv), .cyc_done(cyc_done), .hv_fault(hv_fault),
    .verify_mismatch(verify_mismatch));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // eng bit 0: a flash cycle must run, bit 1: interrupt it
  task automatic cpu_call(input logic [7:0] fn, tg, dat, input logic ec,
      input logic [7:0] er, em, input logic [1:0] eng = 2'b00, input int kind = 0,
      input logic [7:0] key = fiwp_pkg::KEY_VALUE,
      input logic [15:0] addr = fiwp_pkg::ENTRY_ADDR);
    int n;
    int got;
    logic saw_idle;
    logic saw_abort;
    n = 0;
    got = 2;
    saw_idle = 1'b0;
    saw_abort = 1'b0;
    @(posedge clk_sys);
    while (call_ready !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    if (kind == 0) notes.push_back('{ec, er, em});
    call_addr   <= addr;
    call_func   <= fn;
    call_target <= tg;
    call_data   <= dat;
    key_byte    <= key;
    call_valid  <= 1'b1;
    @(posedge clk_sys);
    call_valid <= 1'b0;
    for (n = 0; n < 90; n++) begin
      @(posedge clk_sys);
      if (cpu_idle === 1'b1) saw_idle = 1'b1;
      if (cyc_abort_q === 1'b1) saw_abort = 1'b1;
      if (cpu_idle === 1'b1 && eng[1]) irq_pending <= 1'b1;
      if (call_done_q === 1'b1) begin
        got = 0;
        break;
      end
      if (mcu_reset_q === 1'b1) begin
        got = 1;
        break;
      end
    end
    irq_pending <= 1'b0;
    check("call outcome", 8'(kind), 8'(got));
    if (eng[0]) check("cpu idle", 8'h01, {7'h00, saw_idle});
    if (eng[1]) check("cycle abort", 8'h01, {7'h00, saw_abort});
  endtask : cpu_call

  // frz: key write lands while frozen, so it must be ignored
  task automatic flash_cmd(input logic [7:0] cmd, key, input logic exp_we,
      input logic frz = 1'b0);
    @(posedge clk_sys);
    fcmd_we    <= 1'b1;
    fcmd_wdata <= cmd;
    @(posedge clk_sys);
    fcmd_we     <= 1'b0;
    fdata_we    <= 1'b1;
    fdata_wdata <= key;
    clk_en      <= !frz;
    @(posedge clk_sys);
    fdata_we <= 1'b0;
    clk_en   <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("write enable", {7'h00, exp_we}, {7'h00, write_enable});
  endtask : flash_cmd

  task automatic check_we(input logic exp_we);
    repeat (2) @(posedge clk_sys);
    check("write enable", {7'h00, exp_we}, {7'h00, write_enable});
  endtask : check_we

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  always @(posedge clk_sys) begin
    if (call_done_q === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected done", 8'h00, 8'h01);
      end else begin
        nt = notes.pop_front();
        check("carry", {7'h00, nt.carry}, {7'h00, carry_q});
        check("result", nt.res & nt.mask, result_q & nt.mask);
        check("key clear", 8'h01, {7'h00, key_clear_q});
        check("status unused", 8'h00, {4'h0, status_q[7:4]});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end

  initial begin
    {srst, clk_en, call_valid, fcmd_we, fdata_we, security_block} = 6'b110000;
    {irq_pending, fail_verify, fail_hv} = 3'b000;
    {call_addr, call_func, call_target, call_data} = 40'h0;
    {key_byte, fcmd_wdata, fdata_wdata} = 24'h0;
    busy_cycles = 8'h06;
    prog_mode = fiwp_pkg::MODE_IAP;
    lfsr_q = 32'h01b2_e92b;
    err_count = 0;
    n_compared = 0;
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    check("boot status", 8'h00, boot_status);
    check("write enable", 8'h01, {7'h00, write_enable});
    cpu_call(fiwp_pkg::FN_VERSION, 8'h00, 8'h00, 0, VER, 8'hff);
    cpu_call(fiwp_pkg::FN_VERSION, 8'h00, 8'h00, 0, VER, 8'hff, 0, 2, 8'h96, 16'hff00);
    cpu_call(fiwp_pkg::FN_PROGRAM, 8'h00, 8'h11, 0, 8'h00, 8'hff, 1);
    fail_verify <= 1'b1;
    cpu_call(fiwp_pkg::FN_PROGRAM, 8'h00, 8'h22, 1, 8'h08, 8'hff, 1);
    fail_verify <= 1'b0;
    busy_cycles <= 8'h28;
    fail_hv     <= 1'b1;
    cpu_call(fiwp_pkg::FN_ERASE, 8'h00, 8'h00, 1, 8'h04, 8'hff, 1);
    fail_hv <= 1'b0;
    cpu_call(fiwp_pkg::FN_ERASE, 8'h01, 8'h00, 1, 8'h01, 8'hff, 3);
    cpu_call(fiwp_pkg::FN_SECT_CRC, 8'h00, 8'h00, 1, 8'h01, 8'hff, 3);
    cpu_call(fiwp_pkg::FN_GLOB_CRC, 8'h00, 8'h00, 0, 8'h00, 8'h00, 1);
    security_block <= 1'b1;
    cpu_call(fiwp_pkg::FN_PROGRAM, 8'h00, 8'h33, 1, 8'h02, 8'hff);
    security_block <= 1'b0;
    cpu_call(fiwp_pkg::FN_ERASE, 8'h00, 8'h00, 0, 8'h00, 8'h00, 0, 1, 8'h69);
    cpu_call(fiwp_pkg::FN_MISC_RD, 8'h03, 8'h00, 0, 8'h00, 8'hff, 0, 0, 8'h00);
    cpu_call(fiwp_pkg::FN_MISC_WR, 8'h03, 8'h80, 0, 8'h00, 8'hff);
    check("boot status", 8'h80, boot_status);
    check_we(1'b0);
    cpu_call(fiwp_pkg::FN_PROGRAM, 8'h00, 8'h44, 1, 8'h00, 8'h00);
    flash_cmd(fiwp_pkg::CMD_SET_WE, 8'h96, 1'b1);
    flash_cmd(fiwp_pkg::CMD_CLR_WE, 8'h95, 1'b1);
    flash_cmd(fiwp_pkg::CMD_CLR_WE, 8'h96, 1'b0);
    flash_cmd(fiwp_pkg::CMD_SET_WE, 8'h96, 1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      rv[i] = lfsr_q[7:0];
      flash_cmd(fiwp_pkg::CMD_SET_WE, 8'h96, 1'b1);
      cpu_call(fiwp_pkg::FN_MISC_WR, 8'(i), rv[i], 0, 8'h00, 8'hff);
      check_we(1'b0);
      cpu_call(fiwp_pkg::FN_MISC_RD, 8'(i), 8'h00, 0, rv[i], 8'hff);
    end
    flash_cmd(fiwp_pkg::CMD_SET_WE, 8'h96, 1'b1);
    cpu_call(fiwp_pkg::FN_MISC_WR, 8'h03, 8'hc0, 0, 8'h00, 8'hff);
    flash_cmd(fiwp_pkg::CMD_SET_WE, 8'h96, 1'b1);
    cpu_call(fiwp_pkg::FN_MISC_WR, 8'h00, 8'h5a, 1, 8'h00, 8'h00);
    cpu_call(fiwp_pkg::FN_MISC_RD, 8'h00, 8'h00, 0, rv[0], 8'hff);
    flash_cmd(fiwp_pkg::CMD_SET_WE, 8'h96, 1'b1);
    cpu_call(fiwp_pkg::FN_MISC_WR, fiwp_pkg::TG_CCP, 8'h00, 1, 8'h00, 8'h00);
    check("boot status", 8'hc0, boot_status);
    prog_mode <= fiwp_pkg::MODE_ISP;
    cpu_call(fiwp_pkg::FN_PROGRAM, 8'h00, 8'h55, 0, 8'h00, 8'hff, 1);
    check_we(1'b0);
    prog_mode <= fiwp_pkg::MODE_ICP;
    cpu_call(fiwp_pkg::FN_MISC_WR, 8'h00, 8'h33, 0, 8'h00, 8'hff);
    cpu_call(fiwp_pkg::FN_MISC_RD, 8'h00, 8'h00, 0, 8'h33, 8'hff);
    prog_mode <= fiwp_pkg::MODE_PAR;
    cpu_call(fiwp_pkg::FN_MISC_WR, fiwp_pkg::TG_CCP, 8'h00, 0, 8'h00, 8'hff);
    check("boot status", 8'h00, boot_status);
    repeat (4) @(posedge clk_sys);
    complete_run();
  end
endmodule : fiwp_guard_tb
`default_nettype wire

// ---- fiwp_key_cmd.sv ----
/*
  Keyed command decoder: a command write followed by a key data write.
  Assumes command and data strobes come from same-clock CPU logic.
*/
`timescale 1ns/1ps
`default_nettype none

module fiwp_key_cmd (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       clk_en,
  // register writes
  input  wire logic       fcmd_we,
  input  wire logic [7:0] fcmd_wdata,
  input  wire logic       fdata_we,
  input  wire logic [7:0] fdata_wdata,
  // decoded pulses
  output logic            set_q,
  output logic            clr_q
);

  logic       armed_q;
  logic [7:0] cmd_q;

  // any other command write re-arms with the new code
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      armed_q <= 1'b0;
      cmd_q   <= fiwp_pkg::DATA_ZERO;
    end else if (clk_en) begin
      if (fcmd_we) begin
        armed_q <= 1'b1;
        cmd_q   <= fcmd_wdata;
      end else if (fdata_we) begin
        armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      set_q <= 1'b0;
      clr_q <= 1'b0;
    end else if (clk_en) begin
      set_q <= armed_q && !fcmd_we && fdata_we && fdata_wdata == fiwp_pkg::KEY_VALUE
               && cmd_q == fiwp_pkg::CMD_SET_WE;
      clr_q <= armed_q && !fcmd_we && fdata_we && fdata_wdata == fiwp_pkg::KEY_VALUE
               && cmd_q == fiwp_pkg::CMD_CLR_WE;
    end
  end

endmodule : fiwp_key_cmd
`default_nettype wire

// ---- fiwp_pkg.sv ----
/*
  Constants, field positions and state codes for the flash write guard.
  Assumes a single 20 MHz system clock and synchronous active-high reset.
*/

package fiwp_pkg;

  // entry and key
  localparam logic [15:0] ENTRY_ADDR   = 16'hff03;
  localparam logic [7:0]  KEY_VALUE    = 8'h96;
  localparam logic [7:0]  KEY_RAM_ADDR = 8'hff;

  // flash command register codes
  localparam logic [7:0] CMD_SET_WE = 8'h08;
  localparam logic [7:0] CMD_CLR_WE = 8'h0b;

  // function codes
  localparam logic [7:0] FN_PROGRAM  = 8'h00;
  localparam logic [7:0] FN_VERSION  = 8'h01;
  localparam logic [7:0] FN_MISC_WR  = 8'h02;
  localparam logic [7:0] FN_MISC_RD  = 8'h03;
  localparam logic [7:0] FN_ERASE    = 8'h04;
  localparam logic [7:0] FN_SECT_CRC = 8'h05;
  localparam logic [7:0] FN_GLOB_CRC = 8'h06;

  // misc targets
  localparam logic [7:0] TG_CFG_LAST = 8'h03;
  localparam logic [7:0] TG_CCP      = 8'h10;
  localparam int         CFG_COUNT   = 4;
  localparam int         CFG_BOOT    = 3;
  localparam logic [7:0] CFG_RESET   = 8'h00;

  // boot status byte fields
  localparam int BS_AWE_BIT  = 7;
  localparam int BS_DISABLE_PROTECT_CLEAR_BIT = 7;
  localparam int BS_CWP_BIT  = 6;

  // returned status fields
  localparam int         ST_OI     = 0;
  localparam int         ST_SV     = 1;
  localparam int         ST_HVE    = 2;
  localparam int         ST_VE     = 3;
  localparam int         ST_FLAGS  = 4;
  localparam logic [3:0] ST_UNUSED = 4'h0;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  typedef enum logic [1:0] {
    MODE_IAP = 2'h0,
    MODE_ISP = 2'h1,
    MODE_ICP = 2'h2,
    MODE_PAR = 2'h3
  } fiwp_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_CHECK = 4'h2,
    ST_CYCLE = 4'h4,
    ST_DONE  = 4'h8
  } fiwp_state_type;

endpackage : fiwp_pkg

// ---- fiwp_status_flag.sv ----
/*
  One sticky status flag; a set in the clearing cycle wins.
  Assumes set and clear are same-clock pulses.
*/
`timescale 1ns/1ps
`default_nettype none

module fiwp_status_flag (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic clk_en,
  // control
  input  wire logic set,
  input  wire logic clr,
  // state
  output logic      flag_q
);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (clk_en) begin
      if (set) begin
        flag_q <= 1'b1;
      end else if (clr) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule : fiwp_status_flag
`default_nettype wire
